// ---- order_pkg.sv ----
package order_pkg;

    // Word and memory geometry
    localparam int WORD_W    = 40;
    localparam int HALF_W    = 20;
    localparam int ADDR_W    = 10;
    localparam int FIELD_W   = 12;
    localparam int ORDER_W   = 8;
    localparam int MEM_DEPTH = 1024;

    // Field positions inside a word; bigit 0 is the least significant bit
    localparam int LEFT_LSB       = 20;
    localparam int LEFT_ADDR_LSB  = 20;
    localparam int RIGHT_ADDR_LSB = 0;
    localparam int ORDER_LSB      = 12;
    localparam int IMM_LSB        = 28;
    localparam int SIGN_POS       = 39;

    // Address value that names the quotient register for the load and add orders
    localparam logic [11:0] QUOTIENT_SELECT = 12'h800;

    typedef logic [WORD_W-1:0]  word_t;
    typedef logic [ADDR_W-1:0]  addr_t;
    typedef logic [FIELD_W-1:0] field_t;
    typedef logic [ORDER_W-1:0] order_t;

    // Order codes
    localparam order_t CLR_ADD = 8'haa, CLR_SUB = 8'hab, CLR_ABS = 8'hae, CLR_SUB_ABS = 8'haf;
    localparam order_t HOLD_ADD = 8'hba, HOLD_SUB = 8'hbb, HOLD_ABS = 8'hbe;
    localparam order_t HOLD_SUB_ABS = 8'hbf;
    localparam order_t LOAD_QUO = 8'heb, MUL_ROUND = 8'hda, MUL_FULL = 8'hdb;
    localparam order_t DIVIDE = 8'hdd;
    localparam order_t JUMP_LEFT = 8'hca, JUMP_RIGHT = 8'hcb, COND_LEFT = 8'hcc;
    localparam order_t COND_RIGHT = 8'hcd;
    localparam order_t STORE_QUO = 8'hec, STORE_ACC = 8'hdc;
    localparam order_t SUBST_ADDR_LEFT = 8'hfa, SUBST_ADDR_RIGHT = 8'hfb;
    localparam order_t HALF_WORD_SUBSTITUTE_LEFT = 8'hfc, HALF_WORD_SUBSTITUTE_RIGHT = 8'hfd;
    localparam order_t SHIFT_RIGHT_COUNT = 8'hee, SHIFT_LEFT_COUNT = 8'hde;
    localparam order_t IMM_CLEAR = 8'hef, IMM_HOLD = 8'hdf, CLEAR_SIGN_ORDER = 8'hed;
    localparam order_t PRINT_WORD = 8'hea, TAPE_READ = 8'hff;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_FETCH  = 3'h1,
        ST_FWAIT  = 3'h2,
        ST_DECODE = 3'h3,
        ST_OWAIT  = 3'h4,
        ST_EXEC   = 3'h5,
        ST_PRINT  = 3'h6,
        ST_TAPE   = 3'h7
    } state_t;

    // Complement with respect to 2
    function automatic word_t negate(input word_t value);
        negate = ~value + 40'h1;
    endfunction

    function automatic word_t magnitude(input word_t value);
        magnitude = value[SIGN_POS] ? negate(value) : value;
    endfunction

endpackage

// ---- mem_if.sv ----
`timescale 1ns/1ps
interface mem_if;
    import order_pkg::*;
    logic  en;
    logic  we;
    addr_t addr;
    word_t wdata;
    word_t rdata;

    modport requester (output en, output we, output addr, output wdata, input rdata);
    modport store     (input en, input we, input addr, input wdata, output rdata);
endinterface

// ---- word_memory.sv ----
`timescale 1ns/1ps
module word_memory (
    input wire logic clock,
    mem_if.store     port
);
    import order_pkg::*;

    word_t cells [MEM_DEPTH];
    word_t rdata_reg;

    // Synchronous single port; a read leaves the cell untouched
    always_ff @(posedge clock) begin
        if (port.en && port.we) begin
            cells[port.addr] <= port.wdata;
        end
        if (port.en && !port.we) begin
            rdata_reg <= cells[port.addr];
        end
    end

    assign port.rdata = rdata_reg;
endmodule

// ---- arith_unit.sv ----
`timescale 1ns/1ps
module arith_unit (
    input  wire order_pkg::order_t order,
    input  wire order_pkg::word_t  acc,
    input  wire order_pkg::word_t  quo,
    input  wire order_pkg::word_t  operand,
    input  wire order_pkg::field_t field,
    output order_pkg::word_t       acc_res,
    output order_pkg::word_t       quo_res
);
    import order_pkg::*;

    logic signed [79:0] prod;
    logic signed [79:0] num;
    logic signed [79:0] den;
    logic signed [79:0] quot;
    logic signed [79:0] rem;
    logic signed [79:0] rpair;
    logic        [79:0] lpair;

    // Wide helpers are formed every cycle; the case only picks results
    always_comb begin
        prod    = $signed({{40{operand[39]}}, operand}) * $signed({{40{quo[39]}}, quo});
        num     = $signed({acc[39], acc, 39'h0});
        den     = $signed({{40{operand[39]}}, operand});
        quot    = (operand == 40'h0) ? 80'sh0 : num / den;
        rem     = num - quot * den;
        rpair   = $signed({acc, quo}) >>> field;
        lpair   = {quo, acc} << field;
        acc_res = acc;
        quo_res = quo;
        case (order)
            CLR_ADD:      acc_res = operand;
            CLR_SUB:      acc_res = 40'h0 + negate(operand);
            CLR_ABS:      acc_res = magnitude(operand);
            CLR_SUB_ABS:  acc_res = 40'h0 + negate(magnitude(operand));
            HOLD_ADD:     acc_res = acc + operand;
            HOLD_SUB:     acc_res = acc + negate(operand);
            HOLD_ABS:     acc_res = acc + magnitude(operand);
            HOLD_SUB_ABS: acc_res = acc + negate(magnitude(operand));
            LOAD_QUO:     quo_res = operand;
            MUL_ROUND: begin
                acc_res = {prod[78:40], 1'b1};
                quo_res = 40'h0;
            end
            MUL_FULL: begin
                acc_res = prod[78:39];
                quo_res = {1'b0, prod[38:0]};
            end
            DIVIDE: begin
                quo_res = quot[39:0];
                acc_res = {rem[38:0], 1'b0};
            end
            SHIFT_RIGHT_COUNT: begin
                acc_res = rpair[79:40];
                quo_res = rpair[39:0];
            end
            SHIFT_LEFT_COUNT: begin
                acc_res = acc << field;
                quo_res = lpair[79:40];
            end
            IMM_CLEAR:    acc_res = {field, 28'h0};
            IMM_HOLD:     acc_res = acc + {field, 28'h0};
            CLEAR_SIGN_ORDER: acc_res = {1'b0, acc[38:0]};
            default: begin
                acc_res = acc;
                quo_res = quo;
            end
        endcase
    end
endmodule

// ---- one_address_order_executor.sv ----
`timescale 1ns/1ps
module one_address_order_executor (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              run,
    input  wire logic              load_en,
    input  wire order_pkg::addr_t  load_addr,
    input  wire order_pkg::word_t  load_data,
    input  wire logic              print_ready,
    input  wire logic              tape_valid,
    input  wire order_pkg::word_t  tape_word,
    output logic                   print_valid,
    output order_pkg::word_t       print_word,
    output logic                   tape_ready,
    output order_pkg::word_t       accumulator_out,
    output order_pkg::word_t       quotient_out,
    output order_pkg::addr_t       pc_out,
    output logic                   half_out,
    output logic                   busy
);
    import order_pkg::*;

    state_t state_reg;
    addr_t  pc_reg;
    logic   half_reg;
    logic [HALF_W-1:0] instr_reg;
    word_t  operand_reg;
    word_t  accumulator_register;
    word_t  quotient_register;
    logic   print_valid_reg;
    word_t  print_word_reg;
    logic   tape_ready_reg;
    logic   busy_reg;

    order_t order;
    field_t field;
    word_t  acc_res;
    word_t  quo_res;
    word_t  store_word;
    logic   take_jump;
    logic   peripheral_done;
    logic   order_end;

    mem_if mem ();

    word_memory u_memory (
        .clock (clock),
        .port  (mem.store)
    );

    arith_unit u_arith (
        .order   (order),
        .acc     (accumulator_register),
        .quo     (quotient_register),
        .operand (operand_reg),
        .field   (field),
        .acc_res (acc_res),
        .quo_res (quo_res)
    );

    // Eight load and add orders share the quotient-select address
    function automatic logic is_add_order(input order_t code);
        case (code)
            CLR_ADD, CLR_SUB, CLR_ABS, CLR_SUB_ABS,
            HOLD_ADD, HOLD_SUB, HOLD_ABS, HOLD_SUB_ABS: is_add_order = 1'b1;
            default: is_add_order = 1'b0;
        endcase
    endfunction

    // Orders that need the addressed word read before they act
    function automatic logic reads_memory(input order_t code, input field_t addr);
        case (code)
            LOAD_QUO, MUL_ROUND, MUL_FULL, DIVIDE, PRINT_WORD,
            SUBST_ADDR_LEFT, SUBST_ADDR_RIGHT,
            HALF_WORD_SUBSTITUTE_LEFT, HALF_WORD_SUBSTITUTE_RIGHT: reads_memory = 1'b1;
            default: reads_memory = is_add_order(code) && (addr != QUOTIENT_SELECT);
        endcase
    endfunction

    // Orders that write the addressed word during execute
    function automatic logic writes_memory(input order_t code);
        case (code)
            STORE_QUO, STORE_ACC, SUBST_ADDR_LEFT, SUBST_ADDR_RIGHT,
            HALF_WORD_SUBSTITUTE_LEFT, HALF_WORD_SUBSTITUTE_RIGHT: writes_memory = 1'b1;
            default: writes_memory = 1'b0;
        endcase
    endfunction

    // Run is looked at only while idle or as an order ends
    function automatic state_t run_or_idle(input logic go);
        run_or_idle = go ? ST_FETCH : ST_IDLE;
    endfunction

    assign order = instr_reg[HALF_W-1:ORDER_LSB];
    // field is address, count or immediate
    assign field = instr_reg[FIELD_W-1:0];

    // zero or positive takes the jump
    always_comb begin
        case (order)
            JUMP_LEFT, JUMP_RIGHT: take_jump = 1'b1;
            COND_LEFT, COND_RIGHT: take_jump = !accumulator_register[SIGN_POS];
            default:               take_jump = 1'b0;
        endcase
    end

    // Word written back; substitution merges the word read in decode
    always_comb begin
        case (order)
            STORE_QUO: store_word = quotient_register;
            STORE_ACC: store_word = accumulator_register;
            SUBST_ADDR_LEFT: store_word = {operand_reg[39:32],
                accumulator_register[31:LEFT_ADDR_LSB], operand_reg[19:0]};
            SUBST_ADDR_RIGHT: store_word = {operand_reg[39:12],
                accumulator_register[11:RIGHT_ADDR_LSB]};
            HALF_WORD_SUBSTITUTE_LEFT: store_word = {accumulator_register[39:LEFT_LSB],
                operand_reg[19:0]};
            HALF_WORD_SUBSTITUTE_RIGHT: store_word = {operand_reg[39:LEFT_LSB],
                accumulator_register[19:0]};
            default: store_word = accumulator_register;
        endcase
    end

    // Printer or tape finished its handshake this cycle
    assign peripheral_done = (state_reg == ST_PRINT && print_valid_reg && print_ready) ||
                             (state_reg == ST_TAPE && tape_ready_reg && tape_valid);

    // An order ends at execute, or when its peripheral answers
    assign order_end = (state_reg == ST_EXEC && order != PRINT_WORD && order != TAPE_READ)
                       || peripheral_done;

    // Single memory port; loading only while idle keeps a running program coherent
    always_comb begin
        mem.en    = 1'b0;
        mem.we    = 1'b0;
        mem.addr  = '0;
        mem.wdata = '0;
        case (state_reg)
            ST_IDLE: begin
                if (load_en) begin
                    mem.en    = 1'b1;
                    mem.we    = 1'b1;
                    mem.addr  = load_addr;
                    mem.wdata = load_data;
                end
            end
            ST_FETCH: begin
                // Whole word read; the half is picked when it arrives
                mem.en   = 1'b1;
                mem.addr = pc_reg;
            end
            ST_DECODE: begin
                if (reads_memory(order, field)) begin
                    mem.en   = 1'b1;
                    mem.addr = field[ADDR_W-1:0];
                end
            end
            ST_EXEC: begin
                if (writes_memory(order)) begin
                    mem.en    = 1'b1;
                    mem.we    = 1'b1;
                    mem.addr  = field[ADDR_W-1:0];
                    mem.wdata = store_word;
                end
            end
            ST_TAPE: begin
                if (tape_ready_reg && tape_valid) begin
                    mem.en    = 1'b1;
                    mem.we    = 1'b1;
                    mem.addr  = field[ADDR_W-1:0];
                    mem.wdata = tape_word;
                end
            end
            default: begin
                mem.en = 1'b0;
            end
        endcase
    end

    // Sequencer; a stop request is honoured only between orders
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE:   state_reg <= run_or_idle(run);
                ST_FETCH:  state_reg <= ST_FWAIT;
                ST_FWAIT:  state_reg <= ST_DECODE;
                // Quotient-select operands skip the memory wait
                ST_DECODE: state_reg <= reads_memory(order, field) ? ST_OWAIT : ST_EXEC;
                ST_OWAIT:  state_reg <= ST_EXEC;
                ST_EXEC: begin
                    if (order == PRINT_WORD) begin
                        state_reg <= ST_PRINT;
                    end else if (order == TAPE_READ) begin
                        state_reg <= ST_TAPE;
                    end else begin
                        state_reg <= run_or_idle(run);
                    end
                end
                ST_PRINT, ST_TAPE: begin
                    if (peripheral_done) begin
                        state_reg <= run_or_idle(run);
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Instruction half picked from the fetched word
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            instr_reg <= '0;
        end else if (state_reg == ST_FWAIT) begin
            instr_reg <= half_reg ? mem.rdata[HALF_W-1:0] : mem.rdata[WORD_W-1:LEFT_LSB];
        end
    end

    // Operand latch; the quotient stands in for memory at the select address
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            operand_reg <= '0;
        end else if (state_reg == ST_DECODE) begin
            if (is_add_order(order) && field == QUOTIENT_SELECT) begin
                operand_reg <= quotient_register;
            end
        end else if (state_reg == ST_OWAIT) begin
            // Word read in decode stands on the port now
            operand_reg <= mem.rdata;
        end
    end

    // Arithmetic results land once per order
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            accumulator_register <= '0;
            quotient_register    <= '0;
        end else if (state_reg == ST_EXEC) begin
            accumulator_register <= acc_res;
            quotient_register    <= quo_res;
        end
    end

    // Program position; a right-hand order re-fetches so substitutions are seen
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pc_reg   <= '0;
            half_reg <= 1'b0;
        end else if (order_end) begin
            if (take_jump) begin
                pc_reg   <= field[ADDR_W-1:0];
                half_reg <= (order == JUMP_RIGHT) || (order == COND_RIGHT);
            end else if (!half_reg) begin
                half_reg <= 1'b1;
            end else begin
                // Last word wraps back to word 0
                pc_reg   <= pc_reg + 10'h1;
                half_reg <= 1'b0;
            end
        end
    end

    // Printer handshake; valid holds until the printer accepts
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            print_valid_reg <= 1'b0;
            print_word_reg  <= '0;
        end else if (state_reg == ST_EXEC && order == PRINT_WORD) begin
            print_valid_reg <= 1'b1;
            print_word_reg  <= operand_reg;
        end else if (print_valid_reg && print_ready) begin
            // A ready held high gives a one-cycle request
            print_valid_reg <= 1'b0;
        end
    end

    // Tape reader handshake; a slow reader simply stalls the sequencer
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tape_ready_reg <= 1'b0;
        end else if (state_reg == ST_EXEC && order == TAPE_READ) begin
            tape_ready_reg <= 1'b1;
        end else if (tape_ready_reg && tape_valid) begin
            tape_ready_reg <= 1'b0;
        end
    end

    // Busy flag registered so the port comes from a flip-flop
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg != ST_IDLE) || run;
        end
    end

    // Observation ports
    assign print_valid     = print_valid_reg;
    assign print_word      = print_word_reg;
    assign tape_ready      = tape_ready_reg;
    assign accumulator_out = accumulator_register;
    assign quotient_out    = quotient_register;
    assign pc_out          = pc_reg;
    assign half_out        = half_reg;
    assign busy            = busy_reg;
endmodule

// ---- executor_sva.sv ----
`timescale 1ns/1ps
module executor_sva (
    input wire logic             clock,
    input wire logic             rst_b,
    input wire logic             run,
    input wire logic             print_ready,
    input wire logic             tape_valid,
    input wire logic             print_valid,
    input wire order_pkg::word_t print_word,
    input wire logic             tape_ready,
    input wire order_pkg::word_t accumulator_out,
    input wire order_pkg::addr_t pc_out,
    input wire logic             half_out,
    input wire logic             busy
);
    import order_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    // A peripheral request that is not yet answered
    sequence print_stall;
        print_valid && !print_ready;
    endsequence
    sequence tape_stall;
        tape_ready && !tape_valid;
    endsequence

    // Handshakes with printer and tape reader
    print_hold_a: assert property (print_stall |=> print_valid && $stable(print_word))
        else $error("print word dropped while printer stalls");
    print_done_a: assert property (print_valid && print_ready |=> !print_valid)
        else $error("print request stands after acceptance");
    tape_hold_a: assert property (tape_stall |=> tape_ready)
        else $error("tape request dropped before a word came");
    tape_done_a: assert property (tape_ready && tape_valid |=> !tape_ready)
        else $error("tape request stands after the word came");
    port_excl_a: assert property (!(print_valid && tape_ready))
        else $error("printer and tape served by one order");
    // Sequencing: an order takes four cycles at least, nothing moves while idle
    half_dwell_a: assert property ($changed(half_out) |=> $stable(half_out)[*3])
        else $error("half select changed faster than one order");
    idle_still_a: assert property (!busy && !run |=> $stable(accumulator_out) && $stable(pc_out))
        else $error("state moved while idle");
    acc_busy_a: assert property ($changed(accumulator_out) |-> busy)
        else $error("accumulator changed outside an order");
endmodule

bind one_address_order_executor executor_sva chk_i (.clock, .rst_b, .run, .print_ready,
    .tape_valid, .print_valid, .print_word, .tape_ready, .accumulator_out, .pc_out, .half_out,
    .busy);

// ---- periph_model.sv ----
`timescale 1ns/1ps
module periph_model #(
    parameter order_pkg::word_t TAPE_VAL = 40'h0
) (
    input  wire logic             clock,
    input  wire logic             slow,
    input  wire logic             print_valid,
    input  wire order_pkg::word_t print_word,
    input  wire logic             tape_ready,
    output logic                  print_ready,
    output logic                  tape_valid,
    output order_pkg::word_t      tape_word,
    output order_pkg::word_t      got
);
    import order_pkg::*;
    logic [3:0] wait_reg;

    // Count stall cycles while a request stands, keep the last printed word
    always_ff @(posedge clock) begin
        wait_reg <= (print_valid || tape_ready) ? wait_reg + 4'h1 : 4'h0;
        if (print_valid && print_ready) begin
            got <= print_word;
        end
    end

    assign print_ready = print_valid && (!slow || wait_reg > 4'h2);
    assign tape_valid  = tape_ready && (!slow || wait_reg > 4'h2);
    // Off-frame the line shows the inverse, so a stale sample cannot pass
    assign tape_word   = tape_valid ? TAPE_VAL : ~TAPE_VAL;
endmodule

// ---- test_one_address_order_executor.sv ----
`timescale 1ns/1ps
module test_one_address_order_executor;
    import order_pkg::*;
    localparam word_t TV  = 40'h3c3c5a5a01;
    localparam word_t NEG = 40'he000000000;
    localparam word_t POS = 40'h2000000000;
    logic  clock = 0;
    logic  rst_b = 0;
    logic  run = 0;
    logic  load_en = 0;
    logic  slow = 0;
    addr_t load_addr = '0;
    word_t load_data = '0;
    logic  print_ready, tape_valid, print_valid, tape_ready, half_out, busy;
    word_t tape_word, print_word, accumulator_out, quotient_out, got;
    addr_t pc_out;
    int    failures = 0;
    int    n_compared = 0;

    // 100 ns period
    always #50 clock = ~clock;

    one_address_order_executor dut (.clock, .rst_b, .run, .load_en, .load_addr, .load_data,
        .print_ready, .tape_valid, .tape_word, .print_valid, .print_word, .tape_ready,
        .accumulator_out, .quotient_out, .pc_out, .half_out, .busy);
    periph_model #(.TAPE_VAL(TV)) pm (.clock, .slow, .print_valid, .print_word, .tape_ready,
        .print_ready, .tape_valid, .tape_word, .got);

    task automatic tick;
        @(posedge clock);
        #1;
    endtask

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string n, input word_t s, input word_t e);
        n_compared++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    // Reset for 20 cycles brings pc back to word 0, left half
    task automatic restart;
        rst_b = 0;
        repeat (20) tick;
        rst_b = 1;
        tick;
    endtask

    task automatic ld(input addr_t a, input word_t d);
        load_en = 1;
        load_addr = a;
        load_data = d;
        tick;
        load_en = 0;
        tick;
    endtask

    // One run pulse runs exactly one order; both halves hold it, so either half works
    task automatic ex(input order_t o, input field_t f);
        int i;
        ld(pc_out, {o, f, o, f});
        run = 1;
        tick;
        run = 0;
        for (i = 0; i < 40 && busy !== 1'b0; i++) begin
            tick;
        end
        if (i == 40) begin
            failures++;
            report_and_stop;
        end
    endtask

    task automatic pr(input field_t f, input word_t e);
        ex(PRINT_WORD, f);
        chk("printed word", got, e);
    endtask

    task automatic loc(input addr_t p, input logic h);
        chk("pc", pc_out, p);
        chk("half", half_out, h);
    endtask

    task automatic t_add;
        order_t c[8];
        word_t  v[8];
        word_t  e;
        c = '{CLR_ADD, CLR_SUB, CLR_ABS, CLR_SUB_ABS, HOLD_ADD, HOLD_SUB, HOLD_ABS, HOLD_SUB_ABS};
        v = '{NEG, POS, POS, NEG, NEG, POS, POS, NEG};
        restart;
        ld(10'h100, NEG);
        for (int i = 0; i < 8; i++) begin
            ex(c[i], 12'h100);
            e = (i < 4) ? v[i] : e + v[i];
            chk("accumulator", accumulator_out, e);
        end
        pr(12'h100, NEG);
        ex(LOAD_QUO, 12'h100);
        chk("quotient", quotient_out, NEG);
        ex(HOLD_ADD, QUOTIENT_SELECT);
        chk("accumulator", accumulator_out, NEG + NEG);
        $display("loads and adds done");
    endtask

    task automatic t_mul;
        restart;
        ld(10'h101, 40'h4000000001);
        ld(10'h102, 40'h4000000000);
        ex(LOAD_QUO, 12'h102);
        ex(MUL_ROUND, 12'h101);
        chk("accumulator", accumulator_out, 40'h2000000001);
        chk("quotient", quotient_out, 40'h0);
        ex(LOAD_QUO, 12'h102);
        ex(MUL_FULL, 12'h101);
        chk("accumulator", accumulator_out, POS);
        chk("quotient", quotient_out, 40'h4000000000);
        ex(LOAD_QUO, 12'h101);
        ex(DIVIDE, 12'h102);
        chk("quotient", quotient_out, 40'h4000000000);
        chk("accumulator", accumulator_out, 40'h0);
        ex(COND_LEFT, 12'h00a);
        loc(10'h00a, 0);
        ex(STORE_QUO, 12'h103);
        pr(12'h103, 40'h4000000000);
        $display("multiply and divide done");
    endtask

    task automatic t_flow;
        restart;
        ex(JUMP_LEFT, 12'h007);
        loc(10'h007, 0);
        ex(JUMP_RIGHT, 12'h003);
        loc(10'h003, 1);
        ex(IMM_CLEAR, 12'h801);
        loc(10'h004, 0);
        ex(COND_LEFT, 12'h009);
        loc(10'h004, 1);
        ex(CLEAR_SIGN_ORDER, 12'h000);
        chk("accumulator", accumulator_out, 40'h0010000000);
        ex(COND_RIGHT, 12'h009);
        loc(10'h009, 1);
        $display("transfers done");
    endtask

    // Slow peripherals here, so print and tape stalls are exercised
    task automatic t_store;
        word_t  a, q;
        word_t  mk[4];
        order_t s[4];
        slow = 1;
        restart;
        ex(IMM_CLEAR, 12'habc);
        ex(IMM_HOLD, 12'h001);
        a = 40'habd0000000;
        chk("accumulator", accumulator_out, a);
        ex(STORE_ACC, 12'h104);
        pr(12'h104, a);
        s = '{SUBST_ADDR_LEFT, SUBST_ADDR_RIGHT, HALF_WORD_SUBSTITUTE_LEFT,
              HALF_WORD_SUBSTITUTE_RIGHT};
        mk = '{40'h00fff00000, 40'h0000000fff, 40'hfffff00000, 40'h00000fffff};
        for (int i = 0; i < 4; i++) begin
            ld(10'h105, 40'h5555555555);
            ex(s[i], 12'h105);
            pr(12'h105, (40'h5555555555 & ~mk[i]) | (a & mk[i]));
        end
        q = 40'h0123456789;
        ld(10'h106, q);
        ex(LOAD_QUO, 12'h106);
        // Sign fills the top; the accumulator's low nibble enters the quotient
        ex(SHIFT_RIGHT_COUNT, 12'h004);
        chk("accumulator", accumulator_out, 40'hfabd000000);
        chk("quotient", quotient_out, 40'h0012345678);
        ex(SHIFT_LEFT_COUNT, 12'h004);
        chk("accumulator", accumulator_out, 40'habd0000000);
        chk("quotient", quotient_out, 40'h012345678f);
        ex(TAPE_READ, 12'h107);
        pr(12'h107, TV);
        slow = 0;
        $display("stores, shifts and peripherals done");
    endtask

    initial begin
        t_add;
        t_mul;
        t_flow;
        t_store;
        report_and_stop;
    end
endmodule
